// ### hdl/gac_cfg.svh
/*
 gpio and adc control: register indices, field positions, reset values.
 assumes byte address = 4 * index on the register bus.
*/
`ifndef GAC_CFG_SVH
`define GAC_CFG_SVH
`define GAC_IDX_PIN2_CFG 6'h0d
`define GAC_IDX_IO_CFG 6'h0e
`define GAC_IDX_ADC_CFG 6'h0f
`define GAC_IDX_ADC_OFFS 6'h10
`define GAC_IDX_ADC_VALUE 6'h11
`define GAC_IDX_INT_STATUS 6'h20
`define GAC_IDX_INT_MASK 6'h21
`define GAC_RST_PIN2_CFG 8'h00
`define GAC_RST_IO_CFG 4'h0
`define GAC_RST_ADC_CFG 7'h00
`define GAC_RST_ADC_OFFS 4'h0
`define GAC_BIT_PULLUP 5
`define GAC_BIT_EXT_ST 4
`define GAC_BIT_SDO_IRQ 3
`define GAC_BIT_ADC_DONE 7
`define GAC_BIT_ADC_SEL 4
`define GAC_BIT_ADC_REF 2
`define GAC_INT_ADC 3
`define GAC_FS_COEFF_LO 7'h0e
`define GAC_FS_COEFF_HI 7'h15
`define GAC_OFFS_DIVISOR 1000
`endif

// ### hdl/gac_pkg.sv
/*
 gpio and adc control: shared types.
 assumes gac_cfg.svh supplies the numeric constants.
*/
package gac_pkg;
    typedef enum logic [4:0] {
        GAC_FN_MCU_CLOCK = 5'h00,
        GAC_FN_WAKEUP = 5'h01,
        GAC_FN_LOW_BATT = 5'h02,
        GAC_FN_DIRECT_IN = 5'h03,
        GAC_FN_EXT_FALL = 5'h04,
        GAC_FN_EXT_RISE = 5'h05,
        GAC_FN_EXT_CHANGE = 5'h06,
        GAC_FN_ADC_IN = 5'h07,
        GAC_FN_DIRECT_OUT = 5'h0a,
        GAC_FN_VDD = 5'h1d
    } gac_pin_fn_t;
    typedef enum logic [1:0] {
        GAC_RESP_OKAY = 2'h0,
        GAC_RESP_SLVERR = 2'h2
    } gac_resp_t;
endpackage : gac_pkg

// ### hdl/gac_gpio_adc_control.sv
/*
 gpio pin function, external interrupt, direct io, irq-on-sdo and adc control,
 with an axi4-lite register slave.
 assumes one 40 mhz clock; gpio pins and chip select are asynchronous and are
 synchronised here; the adc core answers a start pulse with a done pulse and result.
*/
// The AXI4-Lite interface to the registers was left to the implementer.
`include "gac_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module gac_gpio_adc_control #(
    parameter int ADDR_W = 8
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] gpio_i,
    output logic [2:0] gpio_o,
    output logic [2:0] gpio_oe_o,
    output logic third_pin_pullup_o,
    input wire logic [4:0] pin0_function_i,
    input wire logic [4:0] pin1_function_i,
    input wire logic mcu_clock_i,
    input wire logic wakeup_timer_expired_i,
    input wire logic battery_low_i,
    input wire logic serial_chip_select_n_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    output logic interrupt_request_n_o,
    output logic adc_start_o,
    input wire logic adc_done_i,
    input wire logic [7:0] adc_result_i,
    output logic [2:0] adc_source_o,
    output logic adc_differential_o,
    output logic [1:0] adc_reference_o,
    output logic [1:0] adc_gain_o,
    output logic [6:0] adc_full_scale_milli_o,
    output logic adc_offset_negative_o,
    output logic [2:0] adc_offset_magnitude_o,
    output logic irq_o
);
    // register state
    logic [7:0] pin2_cfg;
    logic sdo_irq_en;
    logic [2:0] dio;
    logic adc_done;
    logic [2:0] adc_sel;
    logic [1:0] adc_ref;
    logic [1:0] adc_gain;
    logic [3:0] adc_offs;
    logic [7:0] adc_value;
    logic [2:0] ext_status;
    logic [3:0] int_status;
    logic [3:0] int_mask;
    // bus state
    logic aw_held;
    logic w_held;
    logic [5:0] aw_idx;
    logic [7:0] w_byte;
    logic w_lane0;
    // pin sampling
    logic [2:0] gpio_meta;
    logic [2:0] gpio_sync;
    logic [2:0] gpio_prev;
    logic [1:0] sync_fill; // edges count only once the history holds real pin samples
    logic sel_meta;
    logic sel_sync;
    logic [4:0] pin_fn [3];
    logic [2:0] ext_event;
    logic [2:0] pin_direct_in;
    logic wr_fire;
    logic rd_fire;
    logic [5:0] ar_idx;
    logic [7:0] next_rdata;
    logic next_rmapped;
    logic [7:0] io_read;

    function automatic logic is_input_fn(input logic [4:0] fn);
        is_input_fn = (fn == gac_pkg::GAC_FN_DIRECT_IN) ||
                      (fn == gac_pkg::GAC_FN_EXT_FALL) ||
                      (fn == gac_pkg::GAC_FN_EXT_RISE) ||
                      (fn == gac_pkg::GAC_FN_EXT_CHANGE);
    endfunction

    // analogue and input functions leave the pin undriven
    function automatic logic drives_fn(input logic [4:0] fn);
        drives_fn = !is_input_fn(fn) && (fn != gac_pkg::GAC_FN_ADC_IN);
    endfunction

    function automatic logic pin_level(input logic [4:0] fn, input logic dio_bit);
        unique case (fn)
            gac_pkg::GAC_FN_MCU_CLOCK: pin_level = mcu_clock_i;
            gac_pkg::GAC_FN_WAKEUP: pin_level = wakeup_timer_expired_i;
            gac_pkg::GAC_FN_LOW_BATT: pin_level = battery_low_i;
            gac_pkg::GAC_FN_DIRECT_OUT: pin_level = dio_bit;
            gac_pkg::GAC_FN_VDD: pin_level = 1'b1;
            default: pin_level = 1'b0;
        endcase
    endfunction

    function automatic logic edge_hit(input logic [4:0] fn, input logic now, input logic was);
        unique case (fn)
            gac_pkg::GAC_FN_EXT_FALL: edge_hit = was & ~now;
            gac_pkg::GAC_FN_EXT_RISE: edge_hit = ~was & now;
            gac_pkg::GAC_FN_EXT_CHANGE: edge_hit = was ^ now;
            default: edge_hit = 1'b0;
        endcase
    endfunction

    assign pin_fn[0] = pin0_function_i;
    assign pin_fn[1] = pin1_function_i;
    assign pin_fn[2] = pin2_cfg[4:0];

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            gpio_meta <= 3'h0;
            gpio_sync <= 3'h0;
            gpio_prev <= 3'h0;
            sel_meta <= 1'b1;
            sel_sync <= 1'b1;
            sync_fill <= 2'h0;
        end
        else
        begin
            gpio_meta <= gpio_i;
            gpio_sync <= gpio_meta;
            gpio_prev <= gpio_sync;
            sel_meta <= serial_chip_select_n_i;
            sel_sync <= sel_meta;
            if (sync_fill != 2'h3)
                sync_fill <= sync_fill + 2'h1;
        end
    end

    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            gpio_o[i] = pin_level(pin_fn[i], dio[i]);
            gpio_oe_o[i] = drives_fn(pin_fn[i]);
            ext_event[i] = (sync_fill == 2'h3) && edge_hit(pin_fn[i], gpio_sync[i], gpio_prev[i]);
            pin_direct_in[i] = (pin_fn[i] == gac_pkg::GAC_FN_DIRECT_IN);
        end
    end

    assign third_pin_pullup_o = pin2_cfg[`GAC_BIT_PULLUP] & is_input_fn(pin2_cfg[4:0]);

    // interrupt output and sdo routing
    assign irq_o = |(int_status & int_mask);
    assign interrupt_request_n_o = ~irq_o;
    assign sdo_oe_o = sdo_irq_en & sel_sync;
    assign sdo_o = interrupt_request_n_o;

    // adc control decode
    assign adc_source_o = adc_sel;
    assign adc_differential_o = adc_sel[2] & (adc_sel != 3'h7);
    assign adc_reference_o = adc_ref;
    assign adc_gain_o = adc_gain;
    assign adc_full_scale_milli_o = (adc_ref[0] ? `GAC_FS_COEFF_HI : `GAC_FS_COEFF_LO)
        * ({5'h00, adc_gain} + 7'h01);
    assign adc_offset_negative_o = adc_offs[3];
    assign adc_offset_magnitude_o = adc_offs[2:0];

    // axi4-lite write path: address and data taken in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_idx <= 6'h00;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= gac_pkg::GAC_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_idx <= s_axi_awaddr[7:2];
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_byte <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
            if (wr_fire)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                unique case (aw_idx)
                    `GAC_IDX_PIN2_CFG, `GAC_IDX_IO_CFG, `GAC_IDX_ADC_CFG,
                    `GAC_IDX_ADC_OFFS, `GAC_IDX_ADC_VALUE, `GAC_IDX_INT_STATUS,
                    `GAC_IDX_INT_MASK: s_axi_bresp <= gac_pkg::GAC_RESP_OKAY;
                    default: s_axi_bresp <= gac_pkg::GAC_RESP_SLVERR;
                endcase
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    logic wr_en;
    assign wr_en = wr_fire && w_lane0;

    // control register writes
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pin2_cfg <= `GAC_RST_PIN2_CFG;
            {sdo_irq_en, dio} <= `GAC_RST_IO_CFG;
            {adc_sel, adc_ref, adc_gain} <= `GAC_RST_ADC_CFG;
            adc_offs <= `GAC_RST_ADC_OFFS;
            int_mask <= 4'h0;
        end
        else if (wr_en)
        begin
            unique case (aw_idx)
                `GAC_IDX_PIN2_CFG: pin2_cfg <= w_byte;
                `GAC_IDX_IO_CFG: {sdo_irq_en, dio} <= w_byte[3:0];
                `GAC_IDX_ADC_CFG: {adc_sel, adc_ref, adc_gain} <= w_byte[6:0];
                `GAC_IDX_ADC_OFFS: adc_offs <= w_byte[3:0];
                `GAC_IDX_INT_MASK: int_mask <= w_byte[3:0];
                default: int_mask <= int_mask;
            endcase
        end
    end

    // adc start and done; done drops on start, rises with the result
    logic start_req;
    assign start_req = wr_en && (aw_idx == `GAC_IDX_ADC_CFG) && w_byte[`GAC_BIT_ADC_DONE];

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            adc_start_o <= 1'b0;
            adc_done <= 1'b0;
            adc_value <= 8'h00;
        end
        else
        begin
            adc_start_o <= start_req;
            if (adc_done_i)
            begin
                adc_done <= 1'b1;
                adc_value <= adc_result_i;
            end
            else if (start_req)
                adc_done <= 1'b0;
        end
    end

    // read path, one word at a time, answered the cycle after arvalid is taken
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign ar_idx = s_axi_araddr[7:2];

    always_comb
    begin
        io_read = {1'b0, ext_status, sdo_irq_en, 3'h0};
        for (int i = 0; i < 3; i++)
            io_read[i] = pin_direct_in[i] ? gpio_sync[i] : dio[i];
    end

    always_comb
    begin
        next_rmapped = 1'b1;
        unique case (ar_idx)
            `GAC_IDX_PIN2_CFG: next_rdata = pin2_cfg;
            `GAC_IDX_IO_CFG: next_rdata = io_read;
            `GAC_IDX_ADC_CFG: next_rdata = {adc_done, adc_sel, adc_ref, adc_gain};
            `GAC_IDX_ADC_OFFS: next_rdata = {4'h0, adc_offs};
            `GAC_IDX_ADC_VALUE: next_rdata = adc_value;
            `GAC_IDX_INT_STATUS: next_rdata = {4'h0, int_status};
            `GAC_IDX_INT_MASK: next_rdata = {4'h0, int_mask};
            default:
            begin
                next_rdata = 8'h00;
                next_rmapped = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= gac_pkg::GAC_RESP_OKAY;
        end
        else if (rd_fire)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, next_rdata};
            s_axi_rresp <= next_rmapped ? gac_pkg::GAC_RESP_OKAY : gac_pkg::GAC_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // pin interrupt status is cleared by reading it; a new edge in that cycle wins
    logic io_read_clear;
    assign io_read_clear = rd_fire && (ar_idx == `GAC_IDX_IO_CFG);

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ext_status <= 3'h0;
        else
            ext_status <= (io_read_clear ? 3'h0 : ext_status) | ext_event;
    end

    // sticky interrupt status, write one to clear; set beats clear
    logic [3:0] int_set;
    logic [3:0] int_clr;
    assign int_set = {adc_done_i, ext_event};
    assign int_clr = (wr_en && (aw_idx == `GAC_IDX_INT_STATUS)) ? w_byte[3:0] : 4'h0;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            int_status <= 4'h0;
        else
            int_status <= (int_status & ~int_clr) | int_set;
    end
endmodule // gac_gpio_adc_control
`default_nettype wire

// ### verification/gac_adc_model.sv
/*
 adc core model: answers a start pulse with a done pulse and a result after a delay.
 assumes start is a one-cycle pulse in the bench clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module gac_adc_model #(
    parameter int DELAY = 20,
    parameter logic [7:0] RESULT = 8'ha7
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    output logic done_o,
    output logic [7:0] result_o
);
    int cnt;
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cnt <= 0;
        else if (start_i)
            cnt <= DELAY;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
    assign done_o = (cnt == 1);
    // off the done cycle the result is inverted, so a stale capture shows
    assign result_o = done_o ? RESULT : ~RESULT;
endmodule // gac_adc_model
`default_nettype wire

// ### verification/gac_gpio_adc_control_checker.sv
/*
 port-level assertions for the gpio and adc control block.
 assumes a bind from the bench and a single clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module gac_gpio_adc_control_checker (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic s_axi_bvalid,
    input wire logic [2:0] gpio_o,
    input wire logic [2:0] gpio_oe_o,
    input wire logic [4:0] pin0_function_i,
    input wire logic [4:0] pin1_function_i,
    input wire logic mcu_clock_i,
    input wire logic battery_low_i,
    input wire logic serial_chip_select_n_i,
    input wire logic sdo_o,
    input wire logic sdo_oe_o,
    input wire logic interrupt_request_n_o,
    input wire logic adc_start_o,
    input wire logic [2:0] adc_source_o,
    input wire logic adc_differential_o,
    input wire logic [1:0] adc_reference_o,
    input wire logic [1:0] adc_gain_o,
    input wire logic [6:0] adc_full_scale_milli_o,
    input wire logic irq_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    a_irq_polarity: assert property (interrupt_request_n_o == !irq_o)
        else $error("irq pin is not the inverse of irq");
    a_sdo_carries_irq: assert property (sdo_oe_o |-> sdo_o == interrupt_request_n_o)
        else $error("sdo does not carry the irq level");
    a_sdo_deselect: assert property (!serial_chip_select_n_i [*3] |=> !sdo_oe_o)
        else $error("sdo driven while selected");
    a_start_pulse: assert property (adc_start_o |->
        ($past(s_axi_bvalid) || s_axi_bvalid) ##1 !adc_start_o)
        else $error("adc start not a single pulse after a write");
    a_full_scale: assert property (adc_full_scale_milli_o ==
        (adc_reference_o[0] ? 7'd21 : 7'd14) * (7'(adc_gain_o) + 7'd1))
        else $error("full scale does not match gain and reference");
    a_diff_mode: assert property (adc_differential_o ==
        (adc_source_o inside {3'h4, 3'h5, 3'h6}))
        else $error("differential flag does not match source");
    a_pin0_clock: assert property (pin0_function_i == 5'h00 |->
        gpio_oe_o[0] && gpio_o[0] == mcu_clock_i)
        else $error("pin0 does not drive the clock");
    a_pin1_battery: assert property (pin1_function_i == 5'h02 |->
        gpio_oe_o[1] && gpio_o[1] == battery_low_i)
        else $error("pin1 does not drive the battery flag");
    a_pin0_input: assert property (pin0_function_i inside {[5'h03:5'h06]} |->
        !gpio_oe_o[0])
        else $error("pin0 driven while an input");
    c_start: cover property (adc_start_o);
    c_sdo_irq: cover property (sdo_oe_o && !sdo_o);
    c_irq_rise: cover property ($rose(irq_o));
endmodule // gac_gpio_adc_control_checker
`default_nettype wire

// ### verification/tb_gpio_adc_control.sv
/*
 bench for the gpio and adc control block: a table of register cases, then hand tests.
 assumes the adc model and the checker are compiled before this file.
*/
`include "gac_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_gpio_adc_control;
    typedef struct packed {
        logic [5:0] idx;
        logic [7:0] wd;
        logic [7:0] rd;
        logic [1:0] rsp;
        logic pu;
    } gac_row_t;
    localparam logic [7:0] ADC_RES = 8'ha7;
    localparam gac_row_t ROWS [7] = '{
        '{`GAC_IDX_PIN2_CFG, 8'h23, 8'h23, 2'h0, 1'b1},
        '{`GAC_IDX_PIN2_CFG, 8'h3f, 8'h3f, 2'h0, 1'b0},
        '{`GAC_IDX_ADC_OFFS, 8'hfd, 8'h0d, 2'h0, 1'b0},
        '{`GAC_IDX_ADC_CFG, 8'h7b, 8'h7b, 2'h0, 1'b0},
        '{`GAC_IDX_INT_MASK, 8'h0f, 8'h0f, 2'h0, 1'b0},
        '{6'h3f, 8'h55, 8'h00, gac_pkg::GAC_RESP_SLVERR, 1'b0},
        '{`GAC_IDX_ADC_VALUE, 8'hff, 8'h00, 2'h0, 1'b0}};
    localparam logic [5:0] RST_IDX [4] = '{`GAC_IDX_PIN2_CFG, `GAC_IDX_IO_CFG,
        `GAC_IDX_ADC_CFG, `GAC_IDX_ADC_OFFS};
    localparam gac_pkg::gac_pin_fn_t EXT_FN [3] = '{gac_pkg::GAC_FN_EXT_FALL,
        gac_pkg::GAC_FN_EXT_RISE, gac_pkg::GAC_FN_EXT_CHANGE};
    logic mclk_i, rst_n_i, mcu_clock_i, wakeup_timer_expired_i, battery_low_i, sdo_o, sdo_oe_o;
    logic serial_chip_select_n_i, adc_done_i, adc_start_o, irq_o, interrupt_request_n_o;
    logic adc_differential_o, adc_offset_negative_o, third_pin_pullup_o;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, adc_reference_o, adc_gain_o, rsp;
    logic [2:0] gpio_i, gpio_o, gpio_oe_o, adc_source_o, adc_offset_magnitude_o;
    logic [3:0] s_axi_wstrb;
    logic [4:0] pin0_function_i, pin1_function_i;
    logic [6:0] adc_full_scale_milli_o;
    logic [7:0] s_axi_awaddr, s_axi_araddr, adc_result_i;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    int num_errors, comparisons, cycles;

    gac_gpio_adc_control #(.ADDR_W(8)) dut (.mclk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gpio_i, .gpio_o, .gpio_oe_o,
        .third_pin_pullup_o, .pin0_function_i, .pin1_function_i, .mcu_clock_i,
        .wakeup_timer_expired_i, .battery_low_i, .serial_chip_select_n_i, .sdo_o, .sdo_oe_o,
        .interrupt_request_n_o, .adc_start_o, .adc_done_i, .adc_result_i, .adc_source_o,
        .adc_differential_o, .adc_reference_o, .adc_gain_o, .adc_full_scale_milli_o,
        .adc_offset_negative_o, .adc_offset_magnitude_o, .irq_o);
    gac_adc_model #(.DELAY(20), .RESULT(ADC_RES)) u_adc (.mclk_i, .rst_n_i,
        .start_i(adc_start_o), .done_o(adc_done_i), .result_o(adc_result_i));

    initial
    begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end

    task automatic complete_run();
        $display("comparisons %0d, num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge mclk_i)
    begin
        mcu_clock_i <= ~mcu_clock_i;
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            num_errors = num_errors + 1;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    // each item is released at the edge that takes it; the answer is read at its own edge
    task automatic wr(input logic [5:0] idx, input logic [7:0] d, output logic [1:0] r);
        logic b;
        b = 1'b0;
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b)
        begin
            @(posedge mclk_i);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            b = s_axi_bvalid;
            r = s_axi_bresp;
        end
        s_axi_bready <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
        logic v;
        v = 1'b0;
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!v)
        begin
            @(posedge mclk_i);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            v = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
        end
        s_axi_rready <= 1'b0;
        @(posedge mclk_i);
    endtask

    initial
    begin
        rst_n_i = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        {gpio_i, pin0_function_i, pin1_function_i} = 13'h0;
        {mcu_clock_i, wakeup_timer_expired_i, battery_low_i} = 3'h0;
        serial_chip_select_n_i = 1'b1;
        {num_errors, comparisons, cycles} = 96'h0;
        cyc(20);
        rst_n_i <= 1'b1;
        cyc(1);
        chk(gpio_oe_o, 3'h7);
        foreach (RST_IDX[i])
        begin
            rd(RST_IDX[i], rdat, rsp);
            chk(rdat, 32'h0);
        end
        foreach (ROWS[i])
        begin
            wr(ROWS[i].idx, ROWS[i].wd, rsp);
            chk(rsp, ROWS[i].rsp);
            rd(ROWS[i].idx, rdat, rsp);
            chk(rdat, ROWS[i].rd);
            chk(rsp, ROWS[i].rsp);
            chk(third_pin_pullup_o, ROWS[i].pu);
        end
        s_axi_wstrb <= 4'he;
        wr(`GAC_IDX_ADC_OFFS, 8'h03, rsp);
        s_axi_wstrb <= 4'hf;
        chk({adc_offset_negative_o, adc_offset_magnitude_o}, 4'hd);
        chk({adc_source_o, adc_reference_o, adc_gain_o}, 7'h7b);
        pin1_function_i <= gac_pkg::GAC_FN_DIRECT_OUT;
        pin0_function_i <= gac_pkg::GAC_FN_DIRECT_IN;
        gpio_i <= 3'h1;
        wr(`GAC_IDX_IO_CFG, 8'h0a, rsp);
        chk({gpio_oe_o[1], gpio_o[1]}, 2'h3);
        rd(`GAC_IDX_IO_CFG, rdat, rsp);
        chk(rdat, 32'h0b);
        chk({sdo_oe_o, sdo_o}, 2'h3);
        serial_chip_select_n_i <= 1'b0;
        // pin0 settles low here, while still a plain input, so no stray edge reaches the loop
        gpio_i <= 3'h0;
        pin1_function_i <= gac_pkg::GAC_FN_LOW_BATT;
        battery_low_i <= 1'b1;
        cyc(4);
        chk(sdo_oe_o, 1'b0);
        chk({gpio_oe_o[1], gpio_o[1]}, 2'h3);
        pin1_function_i <= gac_pkg::GAC_FN_WAKEUP;
        wakeup_timer_expired_i <= 1'b1;
        battery_low_i <= 1'b0;
        cyc(1);
        chk({gpio_oe_o[1], gpio_o[1]}, 2'h3);
        serial_chip_select_n_i <= 1'b1;
        foreach (EXT_FN[i])
        begin
            pin0_function_i <= EXT_FN[i];
            gpio_i <= 3'h0;
            wr(`GAC_IDX_INT_STATUS, 8'h0f, rsp);
            rd(`GAC_IDX_IO_CFG, rdat, rsp);
            gpio_i <= 3'h1;
            cyc(5);
            rd(`GAC_IDX_IO_CFG, rdat, rsp);
            chk(rdat, {i != 0, 4'ha});
            chk(irq_o, i != 0);
            gpio_i <= 3'h0;
            cyc(5);
            rd(`GAC_IDX_IO_CFG, rdat, rsp);
            chk(rdat, {i != 1, 4'ha});
        end
        wr(`GAC_IDX_INT_MASK, 8'h00, rsp);
        chk(irq_o, 1'b0);
        rd(`GAC_IDX_INT_STATUS, rdat, rsp);
        chk(rdat, 32'h01);
        wr(`GAC_IDX_INT_STATUS, 8'h01, rsp);
        wr(`GAC_IDX_INT_MASK, 8'h0f, rsp);
        chk(irq_o, 1'b0);
        wr(`GAC_IDX_ADC_CFG, 8'hc5, rsp);
        rd(`GAC_IDX_ADC_CFG, rdat, rsp);
        chk(rdat, 32'h45);
        chk({adc_differential_o, adc_full_scale_milli_o}, {1'b1, 7'd42});
        for (int n = 0; n < 100 && irq_o !== 1'b1; n++)
            cyc(1);
        rd(`GAC_IDX_ADC_CFG, rdat, rsp);
        chk(rdat, 32'hc5);
        rd(`GAC_IDX_ADC_VALUE, rdat, rsp);
        chk(rdat, ADC_RES);
        rd(`GAC_IDX_INT_STATUS, rdat, rsp);
        chk(rdat, 32'h1 << `GAC_INT_ADC);
        wr(`GAC_IDX_ADC_CFG, 8'hc5, rsp);
        rd(`GAC_IDX_ADC_CFG, rdat, rsp);
        chk(rdat, 32'h45);
        rst_n_i <= 1'b0;
        cyc(3);
        rst_n_i <= 1'b1;
        cyc(1);
        rd(`GAC_IDX_ADC_OFFS, rdat, rsp);
        chk(rdat, 32'h0);
        complete_run();
    end
endmodule // tb_gpio_adc_control

bind gac_gpio_adc_control gac_gpio_adc_control_checker u_chk (.mclk_i, .rst_n_i, .s_axi_bvalid,
    .gpio_o, .gpio_oe_o, .pin0_function_i, .pin1_function_i, .mcu_clock_i, .battery_low_i,
    .serial_chip_select_n_i, .sdo_o, .sdo_oe_o, .interrupt_request_n_o, .adc_start_o,
    .adc_source_o, .adc_differential_o, .adc_reference_o, .adc_gain_o,
    .adc_full_scale_milli_o, .irq_o);
`default_nettype wire
